// ===== rtl/maf_pkg.sv
/*
 * Package for the station address, group hash filter and PHY management
 * register group. Holds offsets, field positions, reset values and states.
 * Assumes a single 40 MHz clock domain shared by all users.
 */
package maf_pkg;
    localparam logic [7:0]  OFF_STATION_ADDR_HIGH = 8'h84;
    localparam logic [7:0]  OFF_STATION_ADDR_LOW  = 8'h88;
    localparam logic [7:0]  OFF_GROUP_HASH_UPPER  = 8'h8C;
    localparam logic [7:0]  OFF_GROUP_HASH_LOWER  = 8'h90;
    localparam logic [7:0]  OFF_PHY_MGMT_CTRL     = 8'h94;
    localparam logic [7:0]  OFF_PHY_MGMT_VALUE    = 8'h98;
    localparam logic [7:0]  OFF_FILTER_CTRL       = 8'hA4;

    localparam logic [15:0] RST_STATION_ADDR_HIGH = 16'hFFFF;
    localparam logic [31:0] RST_STATION_ADDR_LOW  = 32'h0000000F;
    localparam logic [31:0] RST_GROUP_HASH        = 32'h00000000;
    localparam logic [15:0] RST_PHY_VALUE         = 16'h0000;
    localparam logic [4:0]  RST_PHY_FIELD         = 5'h00;

    localparam int POS_PHY_ADDR_LSB    = 11;
    localparam int POS_PHY_REG_SEL_LSB = 6;
    localparam int POS_PHY_WRITE_SEL   = 1;
    localparam int POS_PHY_PENDING     = 0;
    localparam int POS_ACCEPT_ALL_GRP  = 0;

    localparam logic [31:0] CRC_POLY_REFLECTED = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT          = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        MAF_IDLE = 3'b001,
        MAF_REQ  = 3'b010,
        MAF_DONE = 3'b100
    } maf_mgmt_e;
endpackage

// ===== rtl/maf_phy_if.sv
/*
 * Carrier between the register group and its PHY management request engine.
 * Assumes both ends run on the same clock.
 */
interface maf_phy_if;
    logic        start;
    logic        write_sel;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_sel;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport regs (output start, write_sel, phy_addr, reg_sel, wdata,
                  input done, rdata);
    modport eng  (input start, write_sel, phy_addr, reg_sel, wdata,
                  output done, rdata);
endinterface

// ===== rtl/maf_hash_index.sv
/*
 * Combinational six-bit hash index from a 48-bit destination address.
 * Octet 0 (first on the wire) sits in bits 7:0; bits sent LSB first.
 */
module maf_hash_index (
    input  wire logic [47:0] dest_addr,
    output logic      [5:0]  hash_index
);
    logic [31:0] crc;

    // Reflected CRC-32 over the address, top six bits of the result
    always_comb begin
        crc = maf_pkg::CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            if (crc[0] ^ dest_addr[i]) begin
                crc = (crc >> 1) ^ maf_pkg::CRC_POLY_REFLECTED;
            end else begin
                crc = crc >> 1;
            end
        end
        hash_index = crc[31:26];
    end
endmodule // maf_hash_index

// ===== rtl/maf_phy_engine.sv
/*
 * PHY management request engine: turns one start pulse into a request on
 * the internal PHY register port and returns a one-cycle done pulse.
 * Assumes the PHY answers with an ack level/pulse on the same clock.
 */
module maf_phy_engine (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    maf_phy_if.eng           mgmt,
    output logic             phy_req,
    output logic             phy_we,
    output logic [4:0]       phy_addr,
    output logic [4:0]       phy_reg,
    output logic [15:0]      phy_wdata,
    input  wire logic        phy_ack,
    input  wire logic [15:0] phy_rdata
);
    maf_pkg::maf_mgmt_e state_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= maf_pkg::MAF_IDLE;
        end else begin
            case (state_reg)
                maf_pkg::MAF_IDLE: begin
                    if (mgmt.start) state_reg <= maf_pkg::MAF_REQ;
                end
                maf_pkg::MAF_REQ: begin
                    if (phy_ack) state_reg <= maf_pkg::MAF_DONE;
                end
                maf_pkg::MAF_DONE: state_reg <= maf_pkg::MAF_IDLE;
                default: state_reg <= maf_pkg::MAF_IDLE;
            endcase
        end
    end

    // Request fields latched at start so they stay steady for the PHY
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_we    <= 1'b0;
            phy_addr  <= 5'h00;
            phy_reg   <= 5'h00;
            phy_wdata <= 16'h0000;
        end else if (state_reg == maf_pkg::MAF_IDLE && mgmt.start) begin
            phy_we    <= mgmt.write_sel;
            phy_addr  <= mgmt.phy_addr;
            phy_reg   <= mgmt.reg_sel;
            phy_wdata <= mgmt.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_req    <= 1'b0;
            mgmt.done  <= 1'b0;
            mgmt.rdata <= 16'h0000;
        end else begin
            phy_req   <= (state_reg == maf_pkg::MAF_IDLE && mgmt.start) ||
                         (state_reg == maf_pkg::MAF_REQ && !phy_ack);
            mgmt.done <= (state_reg == maf_pkg::MAF_REQ) && phy_ack;
            if (state_reg == maf_pkg::MAF_REQ && phy_ack) begin
                mgmt.rdata <= phy_rdata;
            end
        end
    end
endmodule // maf_phy_engine

// ===== rtl/maf_regs.sv
/*
 * Station address, group hash filter and PHY management register group.
 * Assumes a same-clock register port and a same-clock PHY management port
 * with a request/acknowledge handshake; frame-side inputs are same-clock.
 */
// Overview of operation
// - Address bits 47:32 in high register low half
// - Address bits 31:0 in low register
// - First received octet maps to low byte
// - Six-bit index: MSB picks word, rest bit
// - Index 0 is lower bit 0, 63 upper 31
// - Selected hash bit one accepts group frame
// - Accept-all-group accepts every group frame
// - Hash table split upper and lower words
// - Register-select field picks the PHY register
// - Write-select chooses PHY write or read
// - Pending flag set by software, self-clears
// - Read data valid once pending clears
// - Data register low 16 bits, upper reserved
module maf_regs (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        frame_valid,
    input  wire logic [47:0] frame_dest,
    output logic             frame_accept,
    output logic             frame_decided,
    output logic             phy_req,
    output logic             phy_we,
    output logic [4:0]       phy_addr,
    output logic [4:0]       phy_reg,
    output logic [15:0]      phy_wdata,
    input  wire logic        phy_ack,
    input  wire logic [15:0] phy_rdata
);
    logic [15:0] station_addr_high_reg;
    logic [31:0] station_addr_low_reg;
    logic [31:0] group_hash_upper_reg;
    logic [31:0] group_hash_lower_reg;
    logic        accept_all_group_reg;
    logic [4:0]  phy_addr_field_reg;
    logic [4:0]  phy_reg_select_reg;
    logic        phy_write_select_reg;
    logic        phy_access_pending_reg;
    logic [15:0] phy_value_reg;
    logic [31:0] rdata_next;
    logic [5:0]  hash_index;
    logic        hash_hit;
    logic        unicast_hit;
    logic        is_group;
    logic [47:0] station_addr;
    logic        start_access;
    logic [63:0] hash_table;

    maf_phy_if mgmt ();

    wire wr_high  = reg_wr && reg_addr == maf_pkg::OFF_STATION_ADDR_HIGH;
    wire wr_low   = reg_wr && reg_addr == maf_pkg::OFF_STATION_ADDR_LOW;
    wire wr_hashu = reg_wr && reg_addr == maf_pkg::OFF_GROUP_HASH_UPPER;
    wire wr_group_hash_lower = reg_wr && reg_addr == maf_pkg::OFF_GROUP_HASH_LOWER;
    wire wr_ctrl  = reg_wr && reg_addr == maf_pkg::OFF_PHY_MGMT_CTRL;
    wire wr_value = reg_wr && reg_addr == maf_pkg::OFF_PHY_MGMT_VALUE;
    wire wr_filt  = reg_wr && reg_addr == maf_pkg::OFF_FILTER_CTRL;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            station_addr_high_reg <= maf_pkg::RST_STATION_ADDR_HIGH;
            station_addr_low_reg  <= maf_pkg::RST_STATION_ADDR_LOW;
        end else begin
            if (wr_high) station_addr_high_reg <= reg_wdata[15:0];
            if (wr_low)  station_addr_low_reg  <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            group_hash_upper_reg <= maf_pkg::RST_GROUP_HASH;
            group_hash_lower_reg <= maf_pkg::RST_GROUP_HASH;
            accept_all_group_reg <= 1'b0;
        end else begin
            if (wr_hashu) group_hash_upper_reg <= reg_wdata;
            if (wr_group_hash_lower) group_hash_lower_reg <= reg_wdata;
            if (wr_filt) begin
                accept_all_group_reg <= reg_wdata[maf_pkg::POS_ACCEPT_ALL_GRP];
            end
        end
    end

    // Control fields frozen while an access runs so the engine sees one
    // consistent request even if software ignores the pending flag
    assign start_access = wr_ctrl && !phy_access_pending_reg &&
                          reg_wdata[maf_pkg::POS_PHY_PENDING];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_addr_field_reg   <= maf_pkg::RST_PHY_FIELD;
            phy_reg_select_reg   <= maf_pkg::RST_PHY_FIELD;
            phy_write_select_reg <= 1'b0;
        end else if (wr_ctrl && !phy_access_pending_reg) begin
            phy_addr_field_reg   <= reg_wdata[maf_pkg::POS_PHY_ADDR_LSB +: 5];
            phy_reg_select_reg   <=
                reg_wdata[maf_pkg::POS_PHY_REG_SEL_LSB +: 5];
            phy_write_select_reg <= reg_wdata[maf_pkg::POS_PHY_WRITE_SEL];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_access_pending_reg <= 1'b0;
        end else if (start_access) begin
            phy_access_pending_reg <= 1'b1;
        end else if (mgmt.done) begin
            phy_access_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_value_reg <= maf_pkg::RST_PHY_VALUE;
        end else if (mgmt.done && !phy_write_select_reg) begin
            phy_value_reg <= mgmt.rdata;
        end else if (wr_value && !phy_access_pending_reg) begin
            phy_value_reg <= reg_wdata[15:0];
        end
    end

    // Start is a pulse; the engine latches the fields on the same edge
    assign mgmt.start     = start_access;
    assign mgmt.write_sel = reg_wdata[maf_pkg::POS_PHY_WRITE_SEL];
    assign mgmt.phy_addr  = reg_wdata[maf_pkg::POS_PHY_ADDR_LSB +: 5];
    assign mgmt.reg_sel   = reg_wdata[maf_pkg::POS_PHY_REG_SEL_LSB +: 5];
    assign mgmt.wdata     = phy_value_reg;

    maf_phy_engine u_engine (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .mgmt      (mgmt),
        .phy_req   (phy_req),
        .phy_we    (phy_we),
        .phy_addr  (phy_addr),
        .phy_reg   (phy_reg),
        .phy_wdata (phy_wdata),
        .phy_ack   (phy_ack),
        .phy_rdata (phy_rdata)
    );

    always_comb begin
        rdata_next = 32'h00000000;
        case (reg_addr)
            maf_pkg::OFF_STATION_ADDR_HIGH:
                rdata_next[15:0] = station_addr_high_reg;
            maf_pkg::OFF_STATION_ADDR_LOW:
                rdata_next = station_addr_low_reg;
            maf_pkg::OFF_GROUP_HASH_UPPER:
                rdata_next = group_hash_upper_reg;
            maf_pkg::OFF_GROUP_HASH_LOWER:
                rdata_next = group_hash_lower_reg;
            maf_pkg::OFF_PHY_MGMT_CTRL: begin
                rdata_next[maf_pkg::POS_PHY_ADDR_LSB +: 5] = phy_addr_field_reg;
                rdata_next[maf_pkg::POS_PHY_REG_SEL_LSB +: 5] =
                    phy_reg_select_reg;
                rdata_next[maf_pkg::POS_PHY_WRITE_SEL] = phy_write_select_reg;
                rdata_next[maf_pkg::POS_PHY_PENDING] = phy_access_pending_reg;
            end
            maf_pkg::OFF_PHY_MGMT_VALUE:
                rdata_next[15:0] = phy_value_reg;
            maf_pkg::OFF_FILTER_CTRL:
                rdata_next[maf_pkg::POS_ACCEPT_ALL_GRP] = accept_all_group_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Octet n of the wire lives in bits 8n+7:8n of the combined address
    assign station_addr = {station_addr_high_reg, station_addr_low_reg};
    assign is_group     = frame_dest[0];
    assign unicast_hit  = frame_dest == station_addr;
    // Flat view of the table, only for the cross-check below
    assign hash_table   = {group_hash_upper_reg, group_hash_lower_reg};

    maf_hash_index u_hash (
        .dest_addr  (frame_dest),
        .hash_index (hash_index)
    );

    // MSB picks the word, low five bits the bit inside it
    assign hash_hit = hash_index[5] ? group_hash_upper_reg[hash_index[4:0]]
                                    : group_hash_lower_reg[hash_index[4:0]];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frame_accept  <= 1'b0;
            frame_decided <= 1'b0;
        end else begin
            frame_decided <= frame_valid;
            if (!frame_valid) begin
                frame_accept <= 1'b0;
            end else if (is_group) begin
                frame_accept <= accept_all_group_reg || hash_hit;
            end else begin
                frame_accept <= unicast_hit;
            end
        end
    end

    property p_pending_clears_on_done;
        @(posedge clk_sys) disable iff (!arst_n)
        mgmt.done && !start_access |=> !phy_access_pending_reg;
    endproperty
    a_pending_clears_on_done: assert property (p_pending_clears_on_done)
        else $error("Pending flag not cleared after done");

    property p_start_sets_pending;
        @(posedge clk_sys) disable iff (!arst_n)
        start_access |=> phy_access_pending_reg ##1 phy_req;
    endproperty
    a_start_sets_pending: assert property (p_start_sets_pending)
        else $error("Start did not raise pending and request");

    property p_read_data_lands;
        @(posedge clk_sys) disable iff (!arst_n)
        mgmt.done && !phy_write_select_reg
        |=> phy_value_reg == $past(mgmt.rdata);
    endproperty
    a_read_data_lands: assert property (p_read_data_lands)
        else $error("PHY read value not stored");

    property p_group_all;
        @(posedge clk_sys) disable iff (!arst_n)
        frame_valid && frame_dest[0] && accept_all_group_reg |=> frame_accept;
    endproperty
    a_group_all: assert property (p_group_all)
        else $error("Group frame refused with accept-all set");

    property p_group_hash;
        @(posedge clk_sys) disable iff (!arst_n)
        frame_valid && frame_dest[0] && !accept_all_group_reg
        |=> frame_accept == $past(hash_table[hash_index]);
    endproperty
    a_group_hash: assert property (p_group_hash)
        else $error("Group decision differs from hash bit");

    property p_unicast;
        @(posedge clk_sys) disable iff (!arst_n)
        frame_valid && !frame_dest[0]
        |=> frame_accept == $past(frame_dest == {station_addr_high_reg,
                                                 station_addr_low_reg});
    endproperty
    a_unicast: assert property (p_unicast)
        else $error("Unicast decision wrong");

    property p_high_reserved;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_rd && reg_addr == maf_pkg::OFF_STATION_ADDR_HIGH
        |=> reg_rdata[31:16] == 16'h0000 &&
            reg_rdata[15:0] == $past(station_addr_high_reg);
    endproperty
    a_high_reserved: assert property (p_high_reserved)
        else $error("High address read wrong");

    property p_value_upper_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        reg_rd && reg_addr == maf_pkg::OFF_PHY_MGMT_VALUE
        |=> reg_rdata[31:16] == 16'h0000;
    endproperty
    a_value_upper_zero: assert property (p_value_upper_zero)
        else $error("Data register upper bits not zero");

    property p_reg_sel_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        phy_access_pending_reg |=> $stable(phy_reg_select_reg);
    endproperty
    a_reg_sel_hold: assert property (p_reg_sel_hold)
        else $error("Register select changed mid access");
endmodule // maf_regs

// ===== verif/maf_phy_model.sv
/*
 * Behavioural model of the internal PHY management register port.
 * Assumes the same clock as the register group. The ack delay is an input.
 */
module maf_phy_model (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [3:0]  ack_delay,
    input  wire logic        phy_req,
    input  wire logic        phy_we,
    input  wire logic [4:0]  phy_reg,
    input  wire logic [15:0] phy_wdata,
    output logic             phy_ack,
    output logic      [15:0] phy_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [32];
    logic [3:0]  cnt;
    logic        served;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phy_ack   <= 1'b0;
            phy_rdata <= 16'h5A5A;
            cnt       <= 4'h0;
            served    <= 1'b0;
        end else begin
            phy_ack   <= 1'b0;
            // Read data toggles outside the ack cycle
            phy_rdata <= ~phy_rdata;
            if (!phy_req) begin
                served <= 1'b0;
                cnt    <= 4'h0;
            end else if (!served) begin
                if (cnt >= ack_delay) begin
                    phy_ack <= 1'b1;
                    served  <= 1'b1;
                    if (phy_we) begin
                        mem[phy_reg] <= phy_wdata;
                    end else begin
                        phy_rdata <= mem[phy_reg];
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule // maf_phy_model

// ===== verif/testbench.sv
/*
 * Self-checking bench for the station address, hash filter and PHY
 * management register group. Assumes the partner model beside it.
 */
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        frame_valid = 1'b0;
    logic [47:0] frame_dest = 48'h0;
    logic        frame_accept, frame_decided, phy_req, phy_we, phy_ack;
    logic [4:0]  phy_addr, phy_reg, seen_addr, seen_reg;
    logic [15:0] phy_wdata, phy_rdata;
    logic [3:0]  phy_delay = 4'h0;
    logic        seen_we;
    logic [31:0] seed = 32'h00000014;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [7:0]  t_addr [8] = '{8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98,
                                8'hA4, 8'h80};
    logic [31:0] t_rst [8] = '{32'h0000FFFF, 32'h0000000F, 32'h0, 32'h0,
                               32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] t_mask [8] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
                                32'hFFFFFFFF, 32'h0, 32'h0000FFFF,
                                32'h00000001, 32'h0};

    maf_regs i_maf_regs (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
        .frame_dest(frame_dest), .frame_accept(frame_accept),
        .frame_decided(frame_decided), .phy_req(phy_req), .phy_we(phy_we),
        .phy_addr(phy_addr), .phy_reg(phy_reg), .phy_wdata(phy_wdata),
        .phy_ack(phy_ack), .phy_rdata(phy_rdata));
    maf_phy_model i_maf_phy_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .ack_delay(phy_delay), .phy_req(phy_req), .phy_we(phy_we),
        .phy_reg(phy_reg), .phy_wdata(phy_wdata), .phy_ack(phy_ack),
        .phy_rdata(phy_rdata));

    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (phy_req === 1'b1) begin
            seen_addr <= phy_addr;
            seen_reg  <= phy_reg;
            seen_we   <= phy_we;
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0],
                            seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [47:0] rnd48();
        logic [31:0] hi;
        hi = rnd();
        return {hi[15:0], rnd()};
    endfunction

    // Expected six-bit index: top bits of reflected CRC, LSB first
    function automatic logic [5:0] hash_idx(input logic [47:0] d);
        logic [31:0] c;
        logic        b;
        c = maf_pkg::CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            b = c[0] ^ d[i];
            c = c >> 1;
            if (b) c = c ^ maf_pkg::CRC_POLY_REFLECTED;
        end
        return c[31:26];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic frm(input logic [47:0] d, input logic exp);
        @(posedge clk_sys);
        frame_dest  <= d;
        frame_valid <= 1'b1;
        @(posedge clk_sys);
        frame_valid <= 1'b0;
        #1;
        `CHK("frame_decided", 1'b1, frame_decided)
        `CHK("frame_accept", exp, frame_accept)
    endtask

    task automatic reset_check();
        logic [31:0] v;
        arst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(t_addr[i], v);
            `CHK("reset value", t_rst[i], v)
        end
    endtask

    task automatic phy_op(input logic we, input logic [4:0] r,
                          input logic [15:0] d, input logic [3:0] dly);
        logic [31:0] v;
        int          n;
        phy_delay <= dly;
        if (we) wr(maf_pkg::OFF_PHY_MGMT_VALUE, {16'hFFFF, d});
        wr(maf_pkg::OFF_PHY_MGMT_CTRL,
           {16'h0, 5'h01, r, 4'h0, we, 1'b1});
        rd(maf_pkg::OFF_PHY_MGMT_CTRL, v);
        `CHK("pending set", 1'b1, v[0])
        // Writes while pending must not disturb the access
        if (dly > 4'h3) begin
            wr(maf_pkg::OFF_PHY_MGMT_VALUE, {16'h0, ~d});
            wr(maf_pkg::OFF_PHY_MGMT_CTRL,
               {16'h0, 5'h01, ~r, 4'h0, ~we, 1'b1});
        end
        n = 0;
        do begin
            rd(maf_pkg::OFF_PHY_MGMT_CTRL, v);
            n++;
        end while (v[0] !== 1'b0 && n < 40);
        `CHK("pending cleared", 1'b0, v[0])
        `CHK("ctrl readback", {16'h0, 5'h01, r, 4'h0, we, 1'b0}, v)
        `CHK("phy_addr", 5'h01, seen_addr)
        `CHK("phy_reg", r, seen_reg)
        `CHK("phy_we", we, seen_we)
        rd(maf_pkg::OFF_PHY_MGMT_VALUE, v);
        `CHK("phy value", {16'h0, d}, v)
    endtask

    initial begin
        logic [31:0] v, w;
        logic [47:0] sa, d;
        logic [4:0]  r;
        logic [15:0] pd;
        reset_check();
        for (int i = 0; i < 8; i++) begin
            if (i == 4) continue;
            w = rnd();
            wr(t_addr[i], w);
            rd(t_addr[i], v);
            `CHK("write readback", w & t_mask[i], v)
        end
        sa = rnd48();
        sa[0] = 1'b0;
        // Readback loop may have left accept-all set at random
        wr(maf_pkg::OFF_FILTER_CTRL, 32'h0);
        wr(maf_pkg::OFF_STATION_ADDR_LOW, sa[31:0]);
        wr(maf_pkg::OFF_STATION_ADDR_HIGH, {16'h0, sa[47:32]});
        frm(sa, 1'b1);
        for (int o = 0; o < 6; o++) frm(sa ^ (48'h2 << (8 * o)), 1'b0);
        for (int i = 0; i < 64; i++) begin
            // Group bit set before hashing: the index covers all 48 bits
            d = rnd48() | 48'h1;
            for (int t = 0; t < 4000 && hash_idx(d) != i; t++) begin
                d = rnd48() | 48'h1;
            end
            if (hash_idx(d) != i) continue;
            v = 32'h1 << i[4:0];
            wr(maf_pkg::OFF_GROUP_HASH_UPPER, i[5] ? v : 32'h0);
            wr(maf_pkg::OFF_GROUP_HASH_LOWER, i[5] ? 32'h0 : v);
            frm(d | 48'h1, 1'b1);
            wr(maf_pkg::OFF_GROUP_HASH_UPPER, i[5] ? ~v : 32'hFFFFFFFF);
            wr(maf_pkg::OFF_GROUP_HASH_LOWER, i[5] ? 32'hFFFFFFFF : ~v);
            frm(d | 48'h1, 1'b0);
        end
        wr(maf_pkg::OFF_GROUP_HASH_UPPER, 32'h0);
        wr(maf_pkg::OFF_GROUP_HASH_LOWER, 32'h0);
        wr(maf_pkg::OFF_FILTER_CTRL, 32'h1);
        frm(d | 48'h1, 1'b1);
        frm(sa ^ 48'h2, 1'b0);
        wr(maf_pkg::OFF_FILTER_CTRL, 32'h0);
        frm(d | 48'h1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            w  = rnd();
            r  = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : w[4:0];
            pd = w[31:16];
            phy_op(1'b1, r, pd, k[0] ? 4'h7 : 4'h0);
            phy_op(1'b0, r, pd, k[0] ? 4'h0 : 4'h9);
        end
        reset_check();
        print_verdict();
    end
endmodule // testbench
